//--- hdl/scd_clock_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Select field drives three-way mux: raw, raw over 256, multiplier.
// - Machine-cycle tick is system tick divided by four.
// - Timers and peripherals run from the undivided system tick.
// - 00 multiplier, 01 reserved, 10 divide-by-four default, 11 low power.
// - Multiplier doubles with factor 0, quadruples with factor 1.
// - Multiplier gives one machine cycle per 2 or 1 source clocks.
// - New rate takes effect at the next machine-cycle boundary.
// - Every select change passes through divide-by-four.
// - Direct moves between non divide-by-four values are rejected.
// - Multiplier entry only from divide-by-four, ring flag 0, sequence done.
// - Sequence deviation keeps the select; unrelated accesses do not count.
// - Ready flag rises after 65536 source cycles with enable set.
// - Multiplier engages on the machine cycle after the 00 write.
// - Leaving the multiplier needs only a plain select write.
// - Auto return to divide-by-four on interrupt acknowledge in low power.
// - Select writes ignored while a serial port is busy.
module scd_clock_ctrl #(
  parameter int unsigned LOCK_OSC_CYCLES = scd_pkg::LOCK_OSC_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic ring_mode_flag_i,
  input wire logic serial_busy_i,
  input wire logic int_ack_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic sys_tick_o,
  output logic mc_tick_o,
  output logic [1:0] clk_sel_o,
  output logic multiplier_ready_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [scd_pkg::LOCK_W-1:0] LOCK_LAST =
    scd_pkg::LOCK_W'(LOCK_OSC_CYCLES - 1);

  scd_pkg::scd_ctl_state_t q;
  scd_pkg::scd_ctl_state_t d;
  scd_clk_if clk_if ();

  logic wr_ctrl;
  logic [1:0] new_sel;
  logic new_ar;
  logic new_fac;
  logic new_me;
  logic sel_change;
  logic sel_ok;
  logic mult_ok;
  logic step_ok;
  logic [7:0] ev;

  // Control image as software sees it
  function automatic logic [7:0] ctrl_image(
    input scd_pkg::scd_ctl_state_t s
  );
    logic [7:0] r;
    r = 8'h00;
    r[scd_pkg::CTRL_SEL_HI:scd_pkg::CTRL_SEL_LO] = s.sel;
    r[scd_pkg::CTRL_AUTO_RET] = s.auto_ret;
    r[scd_pkg::CTRL_FACTOR] = s.factor;
    r[scd_pkg::CTRL_MULT_EN] = s.mult_en;
    return r;
  endfunction : ctrl_image

  // ----------------------------------------------------------------
  // Tick generator
  // ----------------------------------------------------------------
  scd_tick_gen u_tick_gen (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .clk_if(clk_if.gen)
  );

  // Requested select and factor toward the mux
  assign clk_if.req_sel = q.sel;
  assign clk_if.factor = q.factor;

  // ----------------------------------------------------------------
  // Write field decode
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl = we_i && (addr_i == scd_pkg::ADDR_CTRL);
    new_sel = wdata_i[scd_pkg::CTRL_SEL_HI:scd_pkg::CTRL_SEL_LO];
    new_ar = wdata_i[scd_pkg::CTRL_AUTO_RET];
    new_fac = wdata_i[scd_pkg::CTRL_FACTOR];
    new_me = wdata_i[scd_pkg::CTRL_MULT_EN];
    sel_change = wr_ctrl && (new_sel != q.sel);
    // Sequence steps only count in divide-by-four with ring flag clear
    step_ok = (q.sel == scd_pkg::SEL_DIV4) && !ring_mode_flag_i;
    // Entry to multiplier needs a finished, locked sequence
    mult_ok = step_ok && (q.seq == scd_pkg::SEQ_ENABLED) && q.ready &&
              q.mult_en && new_me && (new_fac == q.factor);
  end

  // ----------------------------------------------------------------
  // Select transition check
  // ----------------------------------------------------------------
  always_comb begin
    sel_ok = 1'b0;
    if (serial_busy_i) begin
      sel_ok = 1'b0;
    end else if (new_sel == scd_pkg::SEL_RSVD) begin
      sel_ok = 1'b0;
    end else if (q.sel == scd_pkg::SEL_DIV4) begin
      if (new_sel == scd_pkg::SEL_LOWP) begin
        sel_ok = 1'b1;
      end else begin
        sel_ok = mult_ok;
      end
    end else begin
      // From multiplier or low power only back to divide-by-four
      sel_ok = (new_sel == scd_pkg::SEL_DIV4);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = 8'h00;
    d.rdata = 8'h00;

    // Control register write
    if (wr_ctrl) begin
      d.auto_ret = new_ar;
      if (sel_change) begin
        if (sel_ok) begin
          d.sel = new_sel;
          if (new_sel != scd_pkg::SEL_MULT) begin
            d.seq = scd_pkg::SEQ_IDLE;
          end
        end else begin
          ev[scd_pkg::IRQ_REJECT] = 1'b1;
        end
      end else if (q.sel != scd_pkg::SEL_MULT) begin
        // Factor and enable frozen while the multiplier is engaged
        d.factor = new_fac;
        d.mult_en = new_me;
        if (!step_ok) begin
          d.seq = scd_pkg::SEQ_IDLE;
        end else if (!new_me) begin
          // Enable cleared: step one, then factor step
          if (q.seq == scd_pkg::SEQ_CLEARED ||
              q.seq == scd_pkg::SEQ_FACTOR) begin
            d.seq = scd_pkg::SEQ_FACTOR;
          end else begin
            d.seq = scd_pkg::SEQ_CLEARED;
          end
        end else if ((q.seq == scd_pkg::SEQ_FACTOR ||
                      q.seq == scd_pkg::SEQ_ENABLED) &&
                     new_fac == q.factor) begin
          d.seq = scd_pkg::SEQ_ENABLED;
        end else begin
          d.seq = scd_pkg::SEQ_IDLE;
        end
      end
    end

    // Automatic return from low power on interrupt acknowledge
    if (q.auto_ret && (q.sel == scd_pkg::SEL_LOWP) && int_ack_i &&
        !(sel_change && sel_ok)) begin
      d.sel = scd_pkg::SEL_DIV4;
      ev[scd_pkg::IRQ_SWBACK] = 1'b1;
    end

    // Multiplier lock timer in source clocks
    if (!q.mult_en) begin
      d.lock_cnt = '0;
      d.ready = 1'b0;
    end else if (clk_if.osc_tick && !q.ready) begin
      d.lock_cnt = q.lock_cnt + scd_pkg::LOCK_W'(1);
      if (q.lock_cnt == LOCK_LAST) begin
        d.ready = 1'b1;
        ev[scd_pkg::IRQ_READY] = 1'b1;
      end
    end

    // Applied select seen from the aligned mux
    d.act_seen = clk_if.act_sel;
    if (clk_if.act_sel != q.act_seen) begin
      ev[scd_pkg::IRQ_APPLIED] = 1'b1;
    end

    // Sticky status, write one to clear, set wins
    if (we_i && (addr_i == scd_pkg::ADDR_IRQ_STAT)) begin
      d.irq_stat = (q.irq_stat & ~wdata_i) | ev;
    end else begin
      d.irq_stat = q.irq_stat | ev;
    end
    if (we_i && (addr_i == scd_pkg::ADDR_IRQ_MASK)) begin
      d.irq_mask = wdata_i;
    end
    d.irq = |(d.irq_stat & d.irq_mask);

    // Read data, valid the cycle after the strobe
    if (re_i) begin
      case (addr_i)
        scd_pkg::ADDR_CTRL: d.rdata = ctrl_image(q);
        scd_pkg::ADDR_STATUS: begin
          d.rdata[scd_pkg::STAT_READY] = q.ready;
          d.rdata[scd_pkg::STAT_BUSY] = serial_busy_i;
          d.rdata[scd_pkg::STAT_RING] = ring_mode_flag_i;
          d.rdata[1:0] = clk_if.act_sel;
        end
        scd_pkg::ADDR_IRQ_STAT: d.rdata = q.irq_stat;
        scd_pkg::ADDR_IRQ_MASK: d.rdata = q.irq_mask;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{sel: scd_pkg::SEL_RESET,
             seq: scd_pkg::SEQ_IDLE,
             act_seen: scd_pkg::SEL_RESET,
             irq_mask: scd_pkg::IRQ_MASK_RESET,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
  assign sys_tick_o = clk_if.sys_tick;
  assign mc_tick_o = clk_if.mc_tick;
  assign clk_sel_o = clk_if.act_sel;
  assign multiplier_ready_o = q.ready;

endmodule : scd_clock_ctrl

//--- include/scd_pkg.sv
package scd_pkg;

  // ----------------------------------------------------------------
  // Clock select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_MULT = 2'h0;
  localparam logic [1:0] SEL_RSVD = 2'h1;
  localparam logic [1:0] SEL_DIV4 = 2'h2;
  localparam logic [1:0] SEL_LOWP = 2'h3;
  localparam logic [1:0] SEL_RESET = SEL_DIV4;

  // ----------------------------------------------------------------
  // Rate dividers, in clk_i cycles or in ticks
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned OSC_DIV = 4;
  localparam int unsigned LOWP_DIV = 256;
  localparam int unsigned MC_DIV = 4;
  localparam logic [1:0] OSC_LAST = 2'(OSC_DIV - 1);
  localparam logic [7:0] LOWP_LAST = 8'(LOWP_DIV - 1);
  localparam logic [1:0] MC_LAST = 2'(MC_DIV - 1);
  localparam int unsigned LOCK_OSC_CYCLES_DEF = 65536;
  localparam int unsigned LOCK_W = 17;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SEL_HI = 7;
  localparam int unsigned CTRL_SEL_LO = 6;
  localparam int unsigned CTRL_AUTO_RET = 5;
  localparam int unsigned CTRL_FACTOR = 3;
  localparam int unsigned CTRL_MULT_EN = 1;
  localparam int unsigned STAT_READY = 4;
  localparam int unsigned STAT_BUSY = 3;
  localparam int unsigned STAT_RING = 2;
  localparam int unsigned IRQ_READY = 0;
  localparam int unsigned IRQ_REJECT = 1;
  localparam int unsigned IRQ_SWBACK = 2;
  localparam int unsigned IRQ_APPLIED = 3;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Multiplier enable sequence tracker
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CLEARED = 2'b01,
    SEQ_FACTOR = 2'b10,
    SEQ_ENABLED = 2'b11
  } scd_seq_t;

  typedef struct packed {
    logic [1:0] sel;
    logic auto_ret;
    logic factor;
    logic mult_en;
    scd_seq_t seq;
    logic [LOCK_W-1:0] lock_cnt;
    logic ready;
    logic [1:0] act_seen;
    logic [7:0] irq_stat;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } scd_ctl_state_t;

  typedef struct packed {
    logic [1:0] act_sel;
    logic [1:0] osc_div;
    logic [7:0] lowp_div;
    logic mult_div;
    logic [1:0] mc_div;
    logic osc_tick;
    logic sys_tick;
    logic mc_tick;
  } scd_gen_state_t;

endpackage : scd_pkg

//--- include/scd_clk_if.sv
`timescale 1ns/1ps
interface scd_clk_if;
  logic [1:0] req_sel;
  logic factor;
  logic [1:0] act_sel;
  logic osc_tick;
  logic sys_tick;
  logic mc_tick;

  modport gen (
    input req_sel,
    input factor,
    output act_sel,
    output osc_tick,
    output sys_tick,
    output mc_tick
  );

  modport ctl (
    output req_sel,
    output factor,
    input act_sel,
    input osc_tick,
    input sys_tick,
    input mc_tick
  );
endinterface : scd_clk_if

//--- hdl/scd_tick_gen.sv
`timescale 1ns/1ps
module scd_tick_gen (
  input wire logic clk_i,
  input wire logic resetn_i,
  scd_clk_if.gen clk_if
);

  scd_pkg::scd_gen_state_t q;
  scd_pkg::scd_gen_state_t d;
  logic osc_en;
  logic sys_en;
  logic mc_en;

  // ----------------------------------------------------------------
  // Tick generation and aligned mux switch
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    osc_en = (q.osc_div == scd_pkg::OSC_LAST);
    d.osc_div = q.osc_div + 2'h1;
    if (osc_en) begin
      d.lowp_div = q.lowp_div + 8'h01;
    end
    d.mult_div = ~q.mult_div;
    // Three-way source mux
    case (q.act_sel)
      scd_pkg::SEL_MULT: sys_en = clk_if.factor | q.mult_div;
      scd_pkg::SEL_LOWP: begin
        sys_en = osc_en && (q.lowp_div == scd_pkg::LOWP_LAST);
      end
      default: sys_en = osc_en;
    endcase
    // Machine cycle is system clock over four
    mc_en = sys_en && (q.mc_div == scd_pkg::MC_LAST);
    if (sys_en) begin
      d.mc_div = q.mc_div + 2'h1;
    end
    // New source at a machine cycle boundary, always via divide-by-four
    if (mc_en && (clk_if.req_sel != q.act_sel)) begin
      if ((q.act_sel != scd_pkg::SEL_DIV4) &&
          (clk_if.req_sel != scd_pkg::SEL_DIV4)) begin
        d.act_sel = scd_pkg::SEL_DIV4;
      end else begin
        d.act_sel = clk_if.req_sel;
      end
      d.lowp_div = 8'h00;
      d.mult_div = 1'b0;
    end
    d.osc_tick = osc_en;
    d.sys_tick = sys_en;
    d.mc_tick = mc_en;
  end

  // State register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{act_sel: scd_pkg::SEL_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  assign clk_if.act_sel = q.act_sel;
  assign clk_if.osc_tick = q.osc_tick;
  assign clk_if.sys_tick = q.sys_tick;
  assign clk_if.mc_tick = q.mc_tick;

endmodule : scd_tick_gen

//--- test/scd_clock_ctrl_properties.sv
`timescale 1ns/1ps
module scd_clock_ctrl_chk #(
  parameter int unsigned LOCK_OSC_CYCLES = scd_pkg::LOCK_OSC_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic ring_mode_flag_i,
  input wire logic serial_busy_i,
  input wire logic int_ack_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic sys_tick_o,
  input wire logic mc_tick_o,
  input wire logic [1:0] clk_sel_o,
  input wire logic multiplier_ready_o
);
  localparam logic [1:0] D4 = scd_pkg::SEL_DIV4;
  localparam logic [1:0] LP = scd_pkg::SEL_LOWP;
  // ----------------------------------------------------------------
  // Tick rates, select switching and idle read data
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_mc_div4;
    mc_tick_o && clk_sel_o == D4 ##1 clk_sel_o == D4;
  endsequence
  sequence s_sel_moved;
    $changed(clk_sel_o) && $past(resetn_i);
  endsequence
  property p_mc_div4;
    s_mc_div4 |-> !mc_tick_o [*7];
  endproperty
  a_mc_div4: assert property (p_mc_div4) else $error("mc spacing");
  property p_mc_sys;
    mc_tick_o |-> sys_tick_o;
  endproperty
  a_mc_sys: assert property (p_mc_sys) else $error("mc off sys");
  property p_div4_sys;
    sys_tick_o && !mc_tick_o && clk_sel_o == D4 |=> !sys_tick_o [*3];
  endproperty
  a_div4_sys: assert property (p_div4_sys) else $error("div4 rate");
  property p_pmm_sys;
    sys_tick_o && !mc_tick_o && clk_sel_o == LP |=> !sys_tick_o [*8];
  endproperty
  a_pmm_sys: assert property (p_pmm_sys) else $error("low power rate");
  property p_no_rsvd;
    clk_sel_o != scd_pkg::SEL_RSVD;
  endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved select");
  property p_via_div4;
    s_sel_moved |-> clk_sel_o == D4 || $past(clk_sel_o) == D4;
  endproperty
  a_via_div4: assert property (p_via_div4) else $error("direct move");
  property p_sel_mc;
    s_sel_moved |-> mc_tick_o || $past(mc_tick_o);
  endproperty
  a_sel_mc: assert property (p_sel_mc) else $error("switch off edge");
  property p_mult_ready;
    s_sel_moved ##0 clk_sel_o == scd_pkg::SEL_MULT
      |-> $past(multiplier_ready_o);
  endproperty
  a_mult_ready: assert property (p_mult_ready) else $error("not ready");
  property p_rd_idle;
    !$past(re_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
endmodule : scd_clock_ctrl_chk

bind scd_clock_ctrl scd_clock_ctrl_chk #(
  .LOCK_OSC_CYCLES(LOCK_OSC_CYCLES)
) i_chk (
  .clk_i, .resetn_i, .addr_i, .wdata_i, .we_i, .re_i, .ring_mode_flag_i,
  .serial_busy_i, .int_ack_i, .rdata_o, .irq_o, .sys_tick_o, .mc_tick_o,
  .clk_sel_o, .multiplier_ready_o
);

//--- test/scd_core_model.sv
`timescale 1ns/1ps
module scd_core_model (
  input wire logic clk_i,
  input wire logic ack_req_i,
  input wire logic busy_req_i,
  input wire logic ring_req_i,
  output logic int_ack_o,
  output logic serial_busy_o,
  output logic ring_mode_flag_o
);
  // Core side levels and acknowledge pulse, launched after the edge
  always_ff @(posedge clk_i) begin
    int_ack_o <= ack_req_i;
    serial_busy_o <= busy_req_i;
    ring_mode_flag_o <= ring_req_i;
  end
endmodule : scd_core_model

//--- test/scd_clock_ctrl_tb.sv
`timescale 1ns/1ps
module scd_clock_ctrl_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic ack_q = 1'b0;
  logic busy_q = 1'b0;
  logic ring_q = 1'b0;
  logic int_ack, serial_busy, ring_flag, irq_o, sys_tick_o, mc_tick_o, rdy;
  logic [7:0] rdata_o, rv;
  logic [1:0] clk_sel_o;
  int err_count = 0;
  int n_tests = 0;
  int ns, nm;

  scd_core_model i_core (.clk_i(clk_i), .ack_req_i(ack_q),
    .busy_req_i(busy_q), .ring_req_i(ring_q), .int_ack_o(int_ack),
    .serial_busy_o(serial_busy), .ring_mode_flag_o(ring_flag));
  scd_clock_ctrl #(.LOCK_OSC_CYCLES(8)) i_dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .ring_mode_flag_i(ring_flag), .serial_busy_i(serial_busy),
    .int_ack_i(int_ack), .rdata_o(rdata_o), .irq_o(irq_o),
    .sys_tick_o(sys_tick_o), .mc_tick_o(mc_tick_o), .clk_sel_o(clk_sel_o),
    .multiplier_ready_o(rdy));

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    final_report();
  end
  task automatic final_report();
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input string nm_s, input logic [7:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm_s, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  task automatic wsel(input logic [1:0] v, input int n);
    for (int i = 0; i < n && clk_sel_o !== v; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk("clk_sel", {6'h00, clk_sel_o}, {6'h00, v});
  endtask : wsel
  // Counts system and machine ticks over n cycles
  task automatic cnt(input int n);
    ns = 0;
    nm = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 ns += int'(sys_tick_o === 1'b1);
      nm += int'(mc_tick_o === 1'b1);
    end
  endtask : cnt
  // Ordered multiplier entry, status polled for ready before the select write
  task automatic mult(input logic f);
    wr(4'h0, 8'h80);
    wr(4'h0, {4'h8, f, 3'h0});
    wr(4'h0, {4'h8, f, 3'h2});
    #1 chk("ready", {7'h00, rdy}, 8'h00);
    rv = 8'h00;
    for (int i = 0; i < 100 && rv[4] !== 1'b1; i++) rd(4'h1);
    chk("ready", {7'h00, rdy}, 8'h01);
    wr(4'h0, {4'h0, f, 3'h2});
    wsel(2'h0, 17);
    cnt(16);
    chk("mult sys", 8'(ns), f ? 8'h10 : 8'h08);
    chk("mult mc", 8'(nm), f ? 8'h04 : 8'h02);
    wr(4'h0, {4'h8, f, 3'h2});
    wsel(2'h2, 17);
  endtask : mult

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(4'h0);
    chk("ctrl", rv, 8'h80);
    rd(4'h1);
    chk("status", rv, 8'h02);
    cnt(32);
    chk("div4 sys", 8'(ns), 8'h08);
    chk("div4 mc", 8'(nm), 8'h02);
    wr(4'h3, 8'hFF);
    wr(4'h0, 8'h40);
    rd(4'h0);
    chk("ctrl", rv, 8'h80);
    chk("irq", {7'h00, irq_o}, 8'h01);
    wr(4'h2, 8'hFF);
    repeat (2) @(posedge clk_i);
    #1 chk("irq", {7'h00, irq_o}, 8'h00);
    wr(4'h0, 8'hC0);
    wsel(2'h3, 17);
    cnt(2048);
    chk("lowp sys", 8'(ns), 8'h02);
    wr(4'h0, 8'h0A);
    rd(4'h0);
    chk("ctrl", rv, 8'hC0);
    busy_q <= 1'b1;
    wr(4'h0, 8'h80);
    rd(4'h0);
    chk("ctrl", rv, 8'hC0);
    busy_q <= 1'b0;
    wr(4'h0, 8'hE0);
    ack_q <= 1'b1;
    @(posedge clk_i);
    ack_q <= 1'b0;
    rd(4'h0);
    chk("ctrl", rv, 8'hA0);
    rd(4'h2);
    chk("irq stat", rv, 8'h0E);
    wsel(2'h2, 4100);
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h88);
    wr(4'h0, 8'h0A);
    rd(4'h0);
    chk("sel", {6'h00, rv[7:6]}, 8'h02);
    ring_q <= 1'b1;
    mult_ring();
    ring_q <= 1'b0;
    mult(1'b1);
    mult(1'b0);
    final_report();
  end
  // Full ordered entry while the ring flag is up must be refused
  task automatic mult_ring();
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h88);
    wr(4'h0, 8'h8A);
    repeat (60) @(posedge clk_i);
    wr(4'h0, 8'h0A);
    rd(4'h0);
    chk("sel", {6'h00, rv[7:6]}, 8'h02);
  endtask : mult_ring
endmodule : scd_clock_ctrl_tb
